/* include/amb_consts.vh */
// constants for the address modifier block
`ifndef AMB_CONSTS_VH
`define AMB_CONSTS_VH
`define AMB_REG_CTRL 4'h0
`define AMB_REG_PIVOT 4'h1
`define AMB_REG_TPAGE 4'h2
`define AMB_REG_WPAGE 4'h3
`define AMB_REG_XSTART 4'h4
`define AMB_REG_XEND 4'h5
`define AMB_REG_YSTART 4'h6
`define AMB_REG_YEND 4'h7
`define AMB_REG_CORE 4'h8
`define AMB_PTR_NONE 4'hf
`define AMB_X_EN_BIT 15
`define AMB_Y_EN_BIT 14
`define AMB_BR_EN_BIT 15
`define AMB_WIN_EN_BIT 2
`define AMB_CFG_BIT 7
`define AMB_MODE_DIRECT 3'h0
`define AMB_MODE_IND 3'h1
`define AMB_MODE_POSTINC 3'h2
`define AMB_MODE_POSTDEC 3'h3
`define AMB_MODE_PREINC 3'h4
`define AMB_MODE_PREDEC 3'h5
`define AMB_MODE_REGOFS 3'h6
`define AMB_MODE_LITOFS 3'h7
`define AMB_WORD 16'h0002
`define AMB_WORD_MASK 16'hfffe
`define AMB_CTRL_RESET 16'h0fff
`define AMB_X_SEL 3:0
`define AMB_Y_SEL 7:4
`define AMB_BR_SEL 11:8
`define AMB_PIVOT_FIELD 14:0
`define AMB_WIN_OFS 14:0
`endif

/* design/amb_circ_fix.v */
// circular buffer boundary correction for one address unit
`include "amb_consts.vh"
module amb_circ_fix (
    // address and buffer
    input wire [15:0] i_addr,
    input wire i_up,
    input wire [15:0] i_start,
    input wire [15:0] i_end,
    input wire i_word_only,
    // corrected address
    output reg [15:0] o_addr
);
    reg [15:0] len;
    reg [15:0] a;
    always @* begin
        len = i_end - i_start + `AMB_WORD;
        o_addr = i_addr;
        // magnitude compare so a step past the boundary is still caught
        if (i_up && (i_addr > i_end)) begin
            o_addr = i_addr - len;
        end else if (!i_up && (i_addr < i_start)) begin
            o_addr = i_addr + len;
        end
        a = o_addr;
        if (i_word_only) begin
            a[0] = 1'b0;
        end
        o_addr = a;
    end
endmodule

/* design/amb_addr_mod.v */
// address modifier: modulo, bit-reverse and program space mapping
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "amb_consts.vh"
// Overview of operation
// - pointer select 15 disables X modulo
// - X select bits 3..0, enable bit 15
// - Y select bits 7..4, enable bit 14
// - boundaries use magnitude compares, not equality
// - write back only for pre/post modify
// - bit-reverse only X unit writes
// - pointer and modifier are both mirrored for the add
// - bit-reverse needs select, enable, increment mode
// - pivot bits 14..0 scaled to bytes
// - other modes or byte writes stay normal
// - pointer plus pivot, offset ignored, lsb zero
// - bit-reverse beats modulo in X write
// - 16 entry buffer gives mirrored sequence
// - table address is page over effective address
// - page bit 7 selects configuration memory
// - window address is page over bits 14..0
// - window bit 15 is page bit 0
// - table access allows odd and config addresses
// - window read only, low word only
// - four boundary registers hold buffer limits
// - Y modulo addresses are word aligned
// - window mapping needs core control bit 2
module amb_addr_mod (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // register port
    input wire [3:0] i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [15:0] o_reg_rdata,
    // X read unit request
    input wire i_xr_req,
    input wire [3:0] i_xr_ptr,
    input wire [15:0] i_xr_base,
    input wire [2:0] i_xr_mode,
    input wire [15:0] i_xr_ofs,
    // X write unit request
    input wire i_xw_req,
    input wire [3:0] i_xw_ptr,
    input wire [15:0] i_xw_base,
    input wire [2:0] i_xw_mode,
    input wire [15:0] i_xw_ofs,
    input wire i_xw_byte,
    // Y unit request
    input wire i_y_req,
    input wire [3:0] i_y_ptr,
    input wire [15:0] i_y_base,
    input wire [2:0] i_y_mode,
    input wire [15:0] i_y_ofs,
    // table access request
    input wire i_tbl_req,
    input wire i_tbl_wr,
    input wire [15:0] i_tbl_ea,
    // X read results
    output reg o_xr_valid,
    output reg [15:0] o_xr_addr,
    output reg o_xr_wb,
    output reg [15:0] o_xr_wb_val,
    output reg o_xr_prog,
    output reg [22:0] o_xr_prog_addr,
    // X write results
    output reg o_xw_valid,
    output reg [15:0] o_xw_addr,
    output reg o_xw_wb,
    output reg [15:0] o_xw_wb_val,
    output reg o_xw_prog_blocked,
    // Y results
    output reg o_y_valid,
    output reg [15:0] o_y_addr,
    output reg o_y_wb,
    output reg [15:0] o_y_wb_val,
    // table results
    output reg o_tbl_valid,
    output reg [23:0] o_tbl_addr,
    output reg o_tbl_cfg,
    output reg o_tbl_wr
);
    reg [15:0] ctrl_ff, pivot_ff, xs_ff, xe_ff, ys_ff, ye_ff;
    reg [7:0] tpage_ff, wpage_ff;
    reg core_win_ff;

    function is_modify;
        input [2:0] m;
        begin
            is_modify = (m == `AMB_MODE_POSTINC) || (m == `AMB_MODE_POSTDEC) ||
                        (m == `AMB_MODE_PREINC) || (m == `AMB_MODE_PREDEC);
        end
    endfunction

    function is_incr;
        input [2:0] m;
        begin
            is_incr = (m == `AMB_MODE_POSTINC) || (m == `AMB_MODE_PREINC);
        end
    endfunction

    // decrementing modes walk the buffer downward, so they test the lower boundary
    function is_dec;
        input [2:0] m;
        begin
            is_dec = (m == `AMB_MODE_POSTDEC) || (m == `AMB_MODE_PREDEC);
        end
    endfunction

    // offset step for the mode; decrement steps are the two's complement of the offset
    function [15:0] step;
        input [2:0] m;
        input [15:0] ofs;
        begin
            if (m == `AMB_MODE_POSTDEC || m == `AMB_MODE_PREDEC) begin
                step = 16'h0000 - ofs;
            end else if (m == `AMB_MODE_DIRECT || m == `AMB_MODE_IND) begin
                step = 16'h0000;
            end else begin
                step = ofs;
            end
        end
    endfunction

    // access address: pre-modify and offsets use base plus step
    function [15:0] acc_addr;
        input [2:0] m;
        input [15:0] base;
        input [15:0] ofs;
        begin
            if (m == `AMB_MODE_POSTINC || m == `AMB_MODE_POSTDEC) begin
                acc_addr = base;
            end else begin
                acc_addr = base + step(m, ofs);
            end
        end
    endfunction

    // bit mirror of the carry direction: add with carries flowing downward
    function [15:0] rev_add;
        input [15:0] a;
        input [15:0] b;
        reg [15:0] ra, rb, s;
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1) begin
                ra[k] = a[15-k];
                rb[k] = b[15-k];
            end
            s = ra + rb;
            for (k = 0; k < 16; k = k + 1) begin
                rev_add[k] = s[15-k];
            end
        end
    endfunction

    // enables
    wire x_circ_on = ctrl_ff[`AMB_X_EN_BIT] && (ctrl_ff[`AMB_X_SEL] != `AMB_PTR_NONE);
    wire y_circ_on = ctrl_ff[`AMB_Y_EN_BIT] && (ctrl_ff[`AMB_Y_SEL] != `AMB_PTR_NONE);
    wire br_on = pivot_ff[`AMB_BR_EN_BIT] && (ctrl_ff[`AMB_BR_SEL] != `AMB_PTR_NONE);
    wire [15:0] pivot_bytes = {pivot_ff[`AMB_PIVOT_FIELD], 1'b0};

    // X read: modulo only, never bit-reversed
    wire [15:0] xr_raw = acc_addr(i_xr_mode, i_xr_base, i_xr_ofs);
    wire [15:0] xr_upd = i_xr_base + step(i_xr_mode, i_xr_ofs);
    wire xr_circ = x_circ_on && (i_xr_ptr == ctrl_ff[`AMB_X_SEL]);
    wire [15:0] xr_fix_acc, xr_fix_upd;
    amb_circ_fix u_xr_acc (
        .i_addr(xr_raw),
        .i_up(!is_dec(i_xr_mode)),
        .i_start(xs_ff),
        .i_end(xe_ff),
        .i_word_only(1'b0),
        .o_addr(xr_fix_acc)
    );
    amb_circ_fix u_xr_upd (
        .i_addr(xr_upd),
        .i_up(is_incr(i_xr_mode)),
        .i_start(xs_ff),
        .i_end(xe_ff),
        .i_word_only(1'b0),
        .o_addr(xr_fix_upd)
    );
    wire [15:0] xr_ea = xr_circ ? xr_fix_acc : xr_raw;
    wire xr_in_win = xr_ea[15] && core_win_ff;

    // X write: bit-reverse takes priority over modulo
    wire xw_br = br_on && (i_xw_ptr == ctrl_ff[`AMB_BR_SEL]) && is_incr(i_xw_mode) && !i_xw_byte;
    wire xw_circ = x_circ_on && (i_xw_ptr == ctrl_ff[`AMB_X_SEL]) && !xw_br;
    wire [15:0] xw_raw = acc_addr(i_xw_mode, i_xw_base, i_xw_ofs);
    wire [15:0] xw_upd = i_xw_base + step(i_xw_mode, i_xw_ofs);
    // pointer and pivot are both mirrored for the add, and the sum is mirrored back
    wire [15:0] xw_br_next = rev_add(i_xw_base, pivot_bytes) & `AMB_WORD_MASK;
    wire [15:0] xw_br_acc = (i_xw_mode == `AMB_MODE_PREINC) ? xw_br_next : (i_xw_base & `AMB_WORD_MASK);
    wire [15:0] xw_fix_acc, xw_fix_upd;
    amb_circ_fix u_xw_acc (
        .i_addr(xw_raw),
        .i_up(!is_dec(i_xw_mode)),
        .i_start(xs_ff),
        .i_end(xe_ff),
        .i_word_only(1'b0),
        .o_addr(xw_fix_acc)
    );
    amb_circ_fix u_xw_upd (
        .i_addr(xw_upd),
        .i_up(is_incr(i_xw_mode)),
        .i_start(xs_ff),
        .i_end(xe_ff),
        .i_word_only(1'b0),
        .o_addr(xw_fix_upd)
    );

    // Y unit: modulo, word aligned
    wire [15:0] y_raw = acc_addr(i_y_mode, i_y_base, i_y_ofs);
    wire [15:0] y_upd = i_y_base + step(i_y_mode, i_y_ofs);
    wire y_circ = y_circ_on && (i_y_ptr == ctrl_ff[`AMB_Y_SEL]);
    wire [15:0] y_fix_acc, y_fix_upd;
    amb_circ_fix u_y_acc (
        .i_addr(y_raw),
        .i_up(!is_dec(i_y_mode)),
        .i_start(ys_ff),
        .i_end(ye_ff),
        .i_word_only(1'b1),
        .o_addr(y_fix_acc)
    );
    amb_circ_fix u_y_upd (
        .i_addr(y_upd),
        .i_up(is_incr(i_y_mode)),
        .i_start(ys_ff),
        .i_end(ye_ff),
        .i_word_only(1'b1),
        .o_addr(y_fix_upd)
    );

    // registers, reset leaves every mode off
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_ff <= `AMB_CTRL_RESET;
            pivot_ff <= 16'h0000;
            tpage_ff <= 8'h00;
            wpage_ff <= 8'h00;
            xs_ff <= 16'h0000;
            xe_ff <= 16'h0000;
            ys_ff <= 16'h0000;
            ye_ff <= 16'h0000;
            core_win_ff <= 1'b0;
        end else if (i_reg_wr) begin
            if (i_reg_addr == `AMB_REG_CTRL) begin
                ctrl_ff <= i_reg_wdata;
            end else if (i_reg_addr == `AMB_REG_PIVOT) begin
                pivot_ff <= i_reg_wdata;
            end else if (i_reg_addr == `AMB_REG_TPAGE) begin
                tpage_ff <= i_reg_wdata[7:0];
            end else if (i_reg_addr == `AMB_REG_WPAGE) begin
                wpage_ff <= i_reg_wdata[7:0];
            end else if (i_reg_addr == `AMB_REG_XSTART) begin
                xs_ff <= i_reg_wdata;
            end else if (i_reg_addr == `AMB_REG_XEND) begin
                xe_ff <= i_reg_wdata;
            end else if (i_reg_addr == `AMB_REG_YSTART) begin
                ys_ff <= i_reg_wdata;
            end else if (i_reg_addr == `AMB_REG_YEND) begin
                ye_ff <= i_reg_wdata;
            end else if (i_reg_addr == `AMB_REG_CORE) begin
                core_win_ff <= i_reg_wdata[`AMB_WIN_EN_BIT];
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped offsets
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 16'h0000;
        end else if (!i_reg_rd) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_addr == `AMB_REG_CTRL) begin
            o_reg_rdata <= ctrl_ff;
        end else if (i_reg_addr == `AMB_REG_PIVOT) begin
            o_reg_rdata <= pivot_ff;
        end else if (i_reg_addr == `AMB_REG_TPAGE) begin
            o_reg_rdata <= {8'h00, tpage_ff};
        end else if (i_reg_addr == `AMB_REG_WPAGE) begin
            o_reg_rdata <= {8'h00, wpage_ff};
        end else if (i_reg_addr == `AMB_REG_XSTART) begin
            o_reg_rdata <= xs_ff;
        end else if (i_reg_addr == `AMB_REG_XEND) begin
            o_reg_rdata <= xe_ff;
        end else if (i_reg_addr == `AMB_REG_YSTART) begin
            o_reg_rdata <= ys_ff;
        end else if (i_reg_addr == `AMB_REG_YEND) begin
            o_reg_rdata <= ye_ff;
        end else if (i_reg_addr == `AMB_REG_CORE) begin
            o_reg_rdata <= {13'h0000, x_circ_on, core_win_ff, br_on};
        end else begin
            o_reg_rdata <= 16'h0000;
        end
    end

    // address results, registered one cycle after the request
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_xr_valid <= 1'b0;
            o_xr_addr <= 16'h0000;
            o_xr_wb <= 1'b0;
            o_xr_wb_val <= 16'h0000;
            o_xr_prog <= 1'b0;
            o_xr_prog_addr <= 23'h000000;
            o_xw_valid <= 1'b0;
            o_xw_addr <= 16'h0000;
            o_xw_wb <= 1'b0;
            o_xw_wb_val <= 16'h0000;
            o_xw_prog_blocked <= 1'b0;
            o_y_valid <= 1'b0;
            o_y_addr <= 16'h0000;
            o_y_wb <= 1'b0;
            o_y_wb_val <= 16'h0000;
            o_tbl_valid <= 1'b0;
            o_tbl_addr <= 24'h000000;
            o_tbl_cfg <= 1'b0;
            o_tbl_wr <= 1'b0;
        end else begin
            o_xr_valid <= i_xr_req;
            o_xr_addr <= xr_ea;
            o_xr_wb <= i_xr_req && is_modify(i_xr_mode);
            o_xr_wb_val <= xr_circ ? xr_fix_upd : xr_upd;
            // window suppressed while a table access is in flight
            o_xr_prog <= i_xr_req && xr_in_win && !i_tbl_req;
            o_xr_prog_addr <= {wpage_ff, xr_ea[`AMB_WIN_OFS]};
            o_xw_valid <= i_xw_req;
            o_xw_addr <= xw_br ? xw_br_acc : (xw_circ ? xw_fix_acc : xw_raw);
            o_xw_wb <= i_xw_req && is_modify(i_xw_mode);
            o_xw_wb_val <= xw_br ? xw_br_next : (xw_circ ? xw_fix_upd : xw_upd);
            // writes into the window are refused, it is read only
            o_xw_prog_blocked <= i_xw_req && core_win_ff &&
                (xw_br ? xw_br_acc[15] : (xw_circ ? xw_fix_acc[15] : xw_raw[15]));
            o_y_valid <= i_y_req;
            o_y_addr <= y_circ ? y_fix_acc : (y_raw & `AMB_WORD_MASK);
            o_y_wb <= i_y_req && is_modify(i_y_mode);
            o_y_wb_val <= y_circ ? y_fix_upd : y_upd;
            o_tbl_valid <= i_tbl_req;
            o_tbl_addr <= {tpage_ff, i_tbl_ea};
            o_tbl_cfg <= tpage_ff[`AMB_CFG_BIT];
            o_tbl_wr <= i_tbl_req && i_tbl_wr;
        end
    end
endmodule

/* verif/amb_addr_mod_properties.sv */
// port checker for the address modifier
`include "amb_consts.vh"
module amb_addr_mod_props (
    // clock, reset and requests
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_xr_req,
    input wire [2:0] i_xr_mode,
    input wire i_tbl_req,
    input wire i_tbl_wr,
    input wire [15:0] i_tbl_ea,
    // results
    input wire o_xr_valid,
    input wire [15:0] o_xr_addr,
    input wire o_xr_wb,
    input wire o_xr_prog,
    input wire [22:0] o_xr_prog_addr,
    input wire [15:0] o_xw_addr,
    input wire o_xw_prog_blocked,
    input wire o_y_valid,
    input wire [15:0] o_y_addr,
    input wire o_tbl_valid,
    input wire [23:0] o_tbl_addr,
    input wire o_tbl_cfg,
    input wire o_tbl_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    property p_tbl_addr;
        i_tbl_req |=> o_tbl_valid && o_tbl_addr[15:0] == $past(i_tbl_ea);
    endproperty
    a_tbl_addr: assert property (p_tbl_addr) else $error("table address low half wrong");
    property p_tbl_cfg;
        o_tbl_valid |-> o_tbl_cfg == o_tbl_addr[23];
    endproperty
    a_tbl_cfg: assert property (p_tbl_cfg) else $error("table space flag wrong");
    property p_tbl_wr;
        i_tbl_req |=> o_tbl_wr == $past(i_tbl_wr);
    endproperty
    a_tbl_wr: assert property (p_tbl_wr) else $error("table write flag wrong");
    property p_win_addr;
        o_xr_prog |-> o_xr_addr[15] && o_xr_prog_addr[14:0] == o_xr_addr[14:0];
    endproperty
    a_win_addr: assert property (p_win_addr) else $error("window address wrong");
    // write back follows the mode one cycle later, whatever the buffer state
    property p_wb_mode;
        i_xr_req |=> o_xr_valid &&
            o_xr_wb == ($past(i_xr_mode) >= `AMB_MODE_POSTINC && $past(i_xr_mode) <= `AMB_MODE_PREDEC);
    endproperty
    a_wb_mode: assert property (p_wb_mode) else $error("write back flag wrong");
    property p_y_lsb;
        o_y_valid |-> !o_y_addr[0];
    endproperty
    a_y_lsb: assert property (p_y_lsb) else $error("y address odd");
    property p_blocked;
        o_xw_prog_blocked |-> o_xw_addr[15];
    endproperty
    a_blocked: assert property (p_blocked) else $error("window block on low address");
    property p_reset_quiet;
        disable iff (1'b0) i_rst |-> !(o_xr_valid || o_y_valid || o_tbl_valid || o_xr_wb);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
    c_cfg: cover property (o_tbl_valid && o_tbl_cfg);
    c_win: cover property (o_xr_prog);
    c_blk: cover property (o_xw_prog_blocked);
endmodule
bind amb_addr_mod amb_addr_mod_props i_amb_addr_mod_props (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_xr_req(i_xr_req), .i_xr_mode(i_xr_mode), .i_tbl_req(i_tbl_req),
    .i_tbl_wr(i_tbl_wr), .i_tbl_ea(i_tbl_ea), .o_xr_valid(o_xr_valid), .o_xr_addr(o_xr_addr), .o_xr_wb(o_xr_wb),
    .o_xr_prog(o_xr_prog), .o_xr_prog_addr(o_xr_prog_addr), .o_xw_addr(o_xw_addr),
    .o_xw_prog_blocked(o_xw_prog_blocked), .o_y_valid(o_y_valid), .o_y_addr(o_y_addr), .o_tbl_valid(o_tbl_valid),
    .o_tbl_addr(o_tbl_addr), .o_tbl_cfg(o_tbl_cfg), .o_tbl_wr(o_tbl_wr)
);

/* verif/amb_addr_mod_test.sv */
// self-checking bench for the address modifier
`include "amb_consts.vh"
module amb_addr_mod_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b0;
    logic wr = 1'b0, rd = 1'b0, byt = 1'b0, twr = 1'b0, prog, blk, cfg, twr_o;
    logic [3:0] ra = 4'h0, req = 4'h0, vld_o;
    logic [15:0] wd = 16'h0000, ea = 16'h0000, rdata;
    logic [3:0] ptr [3] = '{4'h0, 4'h0, 4'h0};
    logic [2:0] mode [3] = '{3'h0, 3'h0, 3'h0};
    logic [15:0] base [3] = '{16'h0, 16'h0, 16'h0};
    logic [15:0] ofs [3] = '{16'h0, 16'h0, 16'h0};
    logic [15:0] a_o [3], wv_o [3];
    logic [2:0] wb_o;
    logic [22:0] paddr;
    logic [23:0] taddr;
    logic [31:0] seed = 32'hfd7dbd3e;
    logic [15:0] cv [4] = '{16'hcf53, 16'h4f53, 16'h8f5f, 16'h4ff3};
    logic [3:0] pv [3] = '{4'h3, 4'h5, 4'hf};
    logic [7:0] pg [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    int brt [16] = '{0, 8, 4, 12, 2, 10, 6, 14, 1, 9, 5, 13, 3, 11, 7, 15};
    int fails = 0, n_compared = 0;
    always #2.5 i_ref_clk = ~i_ref_clk;
    amb_addr_mod i_amb_addr_mod (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_xr_req(req[0]), .i_xr_ptr(ptr[0]), .i_xr_base(base[0]), .i_xr_mode(mode[0]),
        .i_xr_ofs(ofs[0]), .i_xw_req(req[1]), .i_xw_ptr(ptr[1]), .i_xw_base(base[1]), .i_xw_mode(mode[1]),
        .i_xw_ofs(ofs[1]), .i_xw_byte(byt), .i_y_req(req[2]), .i_y_ptr(ptr[2]), .i_y_base(base[2]),
        .i_y_mode(mode[2]), .i_y_ofs(ofs[2]), .i_tbl_req(req[3]), .i_tbl_wr(twr), .i_tbl_ea(ea),
        .o_xr_valid(vld_o[0]), .o_xr_addr(a_o[0]), .o_xr_wb(wb_o[0]), .o_xr_wb_val(wv_o[0]), .o_xr_prog(prog),
        .o_xr_prog_addr(paddr), .o_xw_valid(vld_o[1]), .o_xw_addr(a_o[1]), .o_xw_wb(wb_o[1]),
        .o_xw_wb_val(wv_o[1]), .o_xw_prog_blocked(blk), .o_y_valid(vld_o[2]), .o_y_addr(a_o[2]), .o_y_wb(wb_o[2]),
        .o_y_wb_val(wv_o[2]), .o_tbl_valid(vld_o[3]), .o_tbl_addr(taddr), .o_tbl_cfg(cfg), .o_tbl_wr(twr_o)
    );
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // wrap distance is one word more than end minus start
    function logic [15:0] circ(input logic [15:0] a, input logic up, input logic [15:0] s, e);
        if (up && a > e)
            return a - (e - s + 16'h0002);
        if (!up && a < s)
            return a + (e - s + 16'h0002);
        return a;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        wr <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge i_ref_clk);
        wr <= 1'b0;
    endtask
    task reg_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_ref_clk);
        rd <= 1'b1;
        ra <= a;
        @(posedge i_ref_clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task unit(input int u, input logic [3:0] p, input logic [2:0] m, input logic [15:0] b, o, ead,
              input logic ewb, input logic [15:0] ewv);
        @(posedge i_ref_clk);
        req[u] <= 1'b1;
        ptr[u] <= p;
        mode[u] <= m;
        base[u] <= b;
        ofs[u] <= o;
        @(posedge i_ref_clk);
        req[u] <= 1'b0;
        #1;
        check(vld_o[u], 1'b1);
        check(a_o[u], ead);
        check(wb_o[u], ewb);
        if (ewb)
            check(wv_o[u], ewv);
    endtask
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        fails++;
        report_and_stop;
    end
    initial begin
        logic [15:0] b, o, wv, s, e;
        logic en, up, xs;
        i_rst <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        reg_chk(`AMB_REG_CTRL, 16'h0fff);
        reg_chk(`AMB_REG_PIVOT, 16'h0000);
        reg_chk(4'hf, 16'h0000);
        reg_wr(`AMB_REG_XSTART, 16'h1000);
        reg_wr(`AMB_REG_XEND, 16'h100e);
        reg_wr(`AMB_REG_YSTART, 16'h2000);
        reg_wr(`AMB_REG_YEND, 16'h2006);
        reg_chk(`AMB_REG_XEND, 16'h100e);
        $display("test registers done");
        foreach (cv[c]) begin
            reg_wr(`AMB_REG_CTRL, cv[c]);
            foreach (pv[i])
                for (int u = 0; u < 3; u++)
                    for (int m = 1; m < 8; m++) begin
                        xs = u < 2;
                        en = xs ? cv[c][15] && cv[c][3:0] != 4'hf && pv[i] == cv[c][3:0]
                                : cv[c][14] && cv[c][7:4] != 4'hf && pv[i] == cv[c][7:4];
                        s = xs ? 16'h1000 : 16'h2000;
                        e = xs ? 16'h100e : 16'h2006;
                        b = s + 16'(2 * (rnd() % 4));
                        o = m == `AMB_MODE_IND ? 16'h0000 : 16'(2 * (rnd() % 3) + 2);
                        up = m != `AMB_MODE_POSTDEC && m != `AMB_MODE_PREDEC;
                        wv = up ? b + o : b - o;
                        if (en)
                            wv = circ(wv, up, s, e);
                        unit(u, pv[i], 3'(m), b, o, m == `AMB_MODE_POSTINC || m == `AMB_MODE_POSTDEC ? b : wv,
                             m >= `AMB_MODE_POSTINC && m <= `AMB_MODE_PREDEC, wv);
                    end
        end
        unit(2, 4'h0, `AMB_MODE_IND, 16'h2003, 16'h0000, 16'h2002, 1'b0, 16'h0000);
        $display("test circular buffers done");
        reg_wr(`AMB_REG_XSTART, 16'h3000);
        reg_wr(`AMB_REG_XEND, 16'h301e);
        reg_wr(`AMB_REG_PIVOT, 16'h0008);
        reg_wr(`AMB_REG_CTRL, 16'h88f8);
        unit(1, 4'h8, `AMB_MODE_POSTINC, 16'h3010, 16'h0002, 16'h3010, 1'b1, 16'h3012);
        reg_wr(`AMB_REG_PIVOT, 16'h8008);
        for (int k = 0; k < 16; k++)
            unit(1, 4'h8, `AMB_MODE_POSTINC, 16'h3000 + 16'(2 * brt[k]), 16'h0006, 16'h3000 + 16'(2 * brt[k]),
                 1'b1, 16'h3000 + 16'(2 * brt[(k + 1) % 16]));
        unit(1, 4'h8, `AMB_MODE_PREINC, 16'h3000, 16'h0002, 16'h3010, 1'b1, 16'h3010);
        unit(1, 4'h8, `AMB_MODE_POSTDEC, 16'h3010, 16'h0002, 16'h3010, 1'b1, 16'h300e);
        unit(0, 4'h8, `AMB_MODE_POSTINC, 16'h301e, 16'h0004, 16'h301e, 1'b1, 16'h3002);
        @(posedge i_ref_clk);
        byt <= 1'b1;
        unit(1, 4'h8, `AMB_MODE_POSTINC, 16'h3010, 16'h0001, 16'h3010, 1'b1, 16'h3011);
        @(posedge i_ref_clk);
        byt <= 1'b0;
        $display("test bit reverse done");
        foreach (pg[k]) begin
            reg_wr(`AMB_REG_TPAGE, {8'hff, pg[k]});
            b = 16'(rnd());
            @(posedge i_ref_clk);
            req[3] <= 1'b1;
            ea <= b;
            twr <= k[0];
            @(posedge i_ref_clk);
            req[3] <= 1'b0;
            #1;
            check(taddr, {pg[k], b});
            check(cfg, pg[k][7]);
            check(twr_o, k[0]);
            check(vld_o[3], 1'b1);
        end
        reg_chk(`AMB_REG_TPAGE, 16'h00ff);
        reg_wr(`AMB_REG_WPAGE, 16'h0034);
        reg_wr(`AMB_REG_CORE, 16'h0004);
        unit(0, 4'h1, `AMB_MODE_IND, 16'h8abc, 16'h0000, 16'h8abc, 1'b0, 16'h0000);
        check(prog, 1'b1);
        check(paddr, {8'h34, 15'h0abc});
        unit(1, 4'h1, `AMB_MODE_IND, 16'h8000, 16'h0000, 16'h8000, 1'b0, 16'h0000);
        check(blk, 1'b1);
        reg_chk(`AMB_REG_CORE, 16'h0007);
        @(posedge i_ref_clk);
        req <= 4'b1001;
        base[0] <= 16'h8abc;
        @(posedge i_ref_clk);
        req <= 4'h0;
        #1;
        check(vld_o[0], 1'b1);
        check(prog, 1'b0);
        unit(0, 4'h1, `AMB_MODE_IND, 16'h1234, 16'h0000, 16'h1234, 1'b0, 16'h0000);
        check(prog, 1'b0);
        reg_wr(`AMB_REG_CORE, 16'h0000);
        unit(0, 4'h1, `AMB_MODE_IND, 16'h8abc, 16'h0000, 16'h8abc, 1'b0, 16'h0000);
        check(prog, 1'b0);
        $display("test program space done");
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        reg_chk(`AMB_REG_CORE, 16'h0000);
        reg_chk(`AMB_REG_CTRL, 16'h0fff);
        unit(1, 4'h8, `AMB_MODE_POSTINC, 16'h3010, 16'h0002, 16'h3010, 1'b1, 16'h3012);
        $display("test reset done");
        report_and_stop;
    end
endmodule
